//--- logic/mip_core.sv
// Microprogrammed I/O processor core: datapath, control store, status RAM, DMA and interrupt requests.
// Assumes a host bus with one-cycle read/write strobes and a DMA/interrupt arbiter outside.
// Overview of operation
// (RULE_01) Data memory is 1024 by 8, addressed by its address register, never executed.
// (RULE_02) Microcode has no path to write the control store.
// (RULE_03) Branch register loads, shifts right taking top bit from ALU, or holds.
// (RULE_04) Program counter loads on a taken branch, otherwise increments.
// (RULE_05) Control store address is the counter, or maintenance address in maintenance mode.
// (RULE_06) Control store is 1024 by 16, written from host via holding data register.
// (RULE_07) Maintenance instruction register is ORed onto the control store output.
// (RULE_08) Eight-input source mux feeds ALU B; a 32-entry table selects it and move.
// (RULE_09) ALU A comes only from the 16 by 8 scratchpad, addressed by microinstruction.
// (RULE_10) During an output transfer scratchpad location zero is forced onto ALU A.
// (RULE_11) A 32-entry function table picks one of 16 ALU functions.
// (RULE_12) Carry flag captures ALU carry during a move or when the table forces it.
// (RULE_13) Equality flag captures A-equals-B during a move.
// (RULE_14) Status RAM reads two ports at once, writes only through port A.
// (RULE_15) Host reaches control/status bytes; DMA pointers and buffers are micro-only.
// (RULE_16) Five non-overlapping 60 ns phases make each 300 ns microcycle; code gives 50 ns (two-clock) phases and a 50 ns idle tail.
// (RULE_17) Host starts the clock by setting bit 15 of the first control register.
// (RULE_18) Clock pauses when micro writes status RAM during a host write.
// (RULE_19) Clock pauses when micro touches status RAM during a DMA transfer.
// (RULE_20) Microcode requests DMA, byte or word, optionally keeping bus mastership.
// (RULE_21) Interrupt uses one of two switch vectors at level 4 to 7, default 5.
// (RULE_22) Device decodes its switch address, register and read/word/byte-write type.
`timescale 1ns/10ps
`include "mip_regs.svh"
module mip_core import mip_pkg::*; #(
	parameter int INTR_LEVEL = 5
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [17:0] bus_addr,
	input wire logic [17:4] dev_addr_sw,
	input wire logic bus_read,
	input wire logic bus_write,
	input wire logic bus_byte,
	input wire logic [15:0] bus_wdata,
	output logic [15:0] bus_rdata,
	output logic bus_ack,
	output logic dma_req,
	output logic dma_write,
	output logic dma_byte,
	output logic dma_keep_master,
	output logic [17:0] dma_addr,
	output logic [15:0] dma_wdata,
	input wire logic dma_done,
	input wire logic [15:0] dma_rdata,
	output logic intr_req,
	output logic [8:0] intr_vector,
	output logic [2:0] intr_level,
	input wire logic intr_grant,
	input wire logic [8:0] vec_a_sw,
	input wire logic [8:0] vec_b_sw,
	input wire logic [7:0] io_in,
	output logic [7:0] io_out_data,
	output logic io_out_strobe,
	output logic [4:0] clk_phase,
	output logic running
);
	initial begin
		if (INTR_LEVEL < 4 || INTR_LEVEL > 7)
			$error("interrupt level must be 4 to 7");
	end

	function automatic logic [8:0] alu_eval(input logic [3:0] f, input logic [7:0] a, input logic [7:0] b,
		input logic ci);
		case (f)
			4'h0: alu_eval = {1'b0, a} + {1'b0, b};
			4'h1: alu_eval = {1'b0, a} + {1'b0, b} + {8'h00, ci};
			4'h2: alu_eval = {1'b0, a} + {1'b0, ~b} + 9'h001;
			4'h3: alu_eval = {1'b0, a} + {1'b0, ~b} + {8'h00, ci};
			4'h4: alu_eval = {1'b0, a} + 9'h001;
			4'h5: alu_eval = {1'b0, b} + 9'h001;
			4'h6: alu_eval = {1'b0, a} + 9'h0FF;
			4'h7: alu_eval = {1'b0, b};
			4'h8: alu_eval = {1'b0, a};
			4'h9: alu_eval = {1'b0, a & b};
			4'hA: alu_eval = {1'b0, a | b};
			4'hB: alu_eval = {1'b0, a ^ b};
			4'hC: alu_eval = {1'b0, ~a};
			4'hD: alu_eval = {1'b0, ~b};
			4'hE: alu_eval = {1'b0, a & ~b};
			default: alu_eval = 9'h000;
		endcase
	endfunction

	// Table contents: select, move enable, destination
	function automatic logic [7:0] source_select_table(input logic [4:0] idx);
		logic mv;
		mv = !(idx[4:3] == 2'b00 && idx[2:0] == SRC_ZERO);
		source_select_table = {1'b0, idx[4:3], 1'b0, mv, idx[2:0]};
	endfunction

	// Table contents: force-carry flag, ALU function
	function automatic logic [7:0] function_table(input logic [4:0] idx);
		function_table = {3'b000, idx[4], idx[3:0]};
	endfunction

	logic [7:0] data_mem [1024];
	logic [15:0] control_store [1024];
	logic [7:0] scratchpad [16];
	logic [7:0] mp_ram [16];
	logic [9:0] pc_reg, pc_next, data_mem_addr_reg, mar_next;
	logic [7:0] branch_shift_reg, br_next;
	logic carry_reg, carry_next, equal_reg, equal_next;
	logic [15:0] maint_instr_reg, mi_next, cs_hold_reg, csh_next;
	logic [9:0] maint_addr_reg, ma_next;
	logic [15:0] bus_rdata_reg, rd_next, dma_in_reg, din_next, dma_wdata_reg, dwd_next;
	logic bus_ack_reg, ack_next;
	logic [1:0] host_wr_cnt_reg, hwc_next;
	mip_dma_state_e dma_state_reg, dma_state_next;
	logic dma_write_reg, dwr_next, dma_byte_reg, dby_next, dma_keep_reg, dkp_next;
	logic [17:0] dma_addr_reg, dad_next;
	logic intr_req_reg, irq_next, io_strobe_reg, ios_next, running_reg;
	logic [8:0] intr_vector_reg, ivec_next;
	logic [7:0] io_out_reg, io_next;
	logic [2:0] intr_level_reg;
	logic [7:0] ctrl_hi_reg, ctrl_hi_next;
	logic cs_pend_reg, csp_next;
	logic [15:0] instr;
	logic [9:0] cs_addr;
	logic [7:0] src_ent, fn_ent, sp_a, mux_b, mp_a, mp_b;
	logic [8:0] alu_y;
	logic [3:0] sp_addr;
	logic run, maint_mode, exec, stall, move, sel_hit, host_mp_wr, mp_touch, mp_wr_attempt;
	logic sp_we, mem_we, mp_we, cs_we;
	logic [3:0] mp_waddr;
	logic [7:0] mp_wdata;
	logic [2:0] reg_idx;
	mip_class_e cls;
	mip_sub_e sub;

	// Reset copy of control byte 1: the status RAM is not reset, so the clock cannot start from garbage
	assign run = ctrl_hi_reg[`MIP_CTRL_RUN_BIT - 8]; // RULE_17
	assign maint_mode = ctrl_hi_reg[`MIP_CTRL_MAINT_BIT - 8];
	assign cs_addr = maint_mode ? maint_addr_reg : pc_reg; // RULE_05
	assign instr = control_store[cs_addr] | maint_instr_reg; // RULE_07
	assign cls = mip_class_e'(instr[15:14]);
	assign sub = mip_sub_e'(instr[13:12]);
	assign src_ent = source_select_table(instr[13:9]); // RULE_08
	assign fn_ent = function_table({instr[8], instr[7:4]}); // RULE_11
	assign move = cls == CL_ALU && src_ent[3];
	// Output transfers always present location zero to the A side
	assign sp_addr = (cls == CL_MISC && sub == SUB_IO) ? 4'h0 : instr[3:0]; // RULE_10
	assign sp_a = scratchpad[sp_addr]; // RULE_09
	assign mp_a = mp_ram[instr[3:0]];
	assign mp_b = mp_ram[branch_shift_reg[3:0]]; // RULE_14
	always_comb begin
		case (mip_src_e'(src_ent[2:0]))
			SRC_BRANCH: mux_b = branch_shift_reg;
			SRC_MEM: mux_b = data_mem[data_mem_addr_reg];
			SRC_MPA: mux_b = mp_a;
			SRC_MPB: mux_b = mp_b;
			SRC_DMA_LO: mux_b = dma_in_reg[7:0];
			SRC_DMA_HI: mux_b = dma_in_reg[15:8];
			SRC_IO: mux_b = io_in;
			default: mux_b = 8'h00;
		endcase
	end
	assign alu_y = alu_eval(fn_ent[3:0], sp_a, mux_b, carry_reg);

	// Host side decode: 16-byte window at the switch address, word index in bits 3:1
	assign sel_hit = bus_addr[17:4] == dev_addr_sw; // RULE_22
	assign reg_idx = bus_addr[3:1];
	assign host_mp_wr = sel_hit && bus_write && reg_idx <= `MIP_REG_MP_LAST; // RULE_15
	assign mp_wr_attempt = cls == CL_MISC && sub == SUB_MPWR;
	// Pointers are read at DMA start, so a start counts as a status RAM access
	assign mp_touch = mp_wr_attempt || (cls == CL_MISC && sub == SUB_DMA)
		|| (cls == CL_ALU && (src_ent[2:0] == SRC_MPA || src_ent[2:0] == SRC_MPB));
	assign stall = (mp_wr_attempt && (host_wr_cnt_reg != 2'b00 || host_mp_wr)) // RULE_18
		|| (mp_touch && dma_state_reg == DMA_BUSY); // RULE_19

	mip_phase_gen u_phase (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.run(run),
		.stall(stall),
		.phase(clk_phase),
		.exec(exec)
	);

	// Host owns status RAM writes in its cycle; the stall keeps the micro off port A then
	always_comb begin
		mp_we = 1'b0;
		mp_waddr = 4'h0;
		mp_wdata = 8'h00;
		if (host_mp_wr) begin
			mp_we = 1'b1;
			mp_waddr = {1'b0, reg_idx[1:0], bus_byte ? bus_addr[0] : 1'b0};
			mp_wdata = (bus_byte && bus_addr[0]) ? bus_wdata[15:8] : bus_wdata[7:0];
		end else if (exec && mp_wr_attempt) begin
			mp_we = 1'b1;
			mp_waddr = instr[7:4];
			mp_wdata = sp_a;
		end
	end
	assign sp_we = exec && ((move && src_ent[6:5] == DST_SP) || cls == CL_IMM);
	assign mem_we = exec && move && src_ent[6:5] == DST_MEM; // RULE_01
	// Only the host strobe reaches this enable
	assign cs_we = sel_hit && bus_write && !bus_byte && reg_idx == `MIP_REG_CS_DATA
		&& ctrl_hi_reg[`MIP_CTRL_CSWR_BIT - 8]; // RULE_02 RULE_06

	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (mp_we)
				mp_ram[mp_waddr] <= mp_wdata;
			if (host_mp_wr && !bus_byte)
				mp_ram[{1'b0, reg_idx[1:0], 1'b1}] <= bus_wdata[15:8];
			if (sp_we)
				scratchpad[instr[3:0]] <= (cls == CL_IMM) ? instr[11:4] : alu_y[7:0];
			if (mem_we)
				data_mem[data_mem_addr_reg] <= alu_y[7:0];
			if (cs_pend_reg)
				control_store[maint_addr_reg] <= cs_hold_reg; // RULE_06
		end
	end

	always_comb begin
		pc_next = pc_reg;
		mar_next = data_mem_addr_reg;
		br_next = branch_shift_reg;
		carry_next = carry_reg;
		equal_next = equal_reg;
		io_next = io_out_reg;
		ios_next = 1'b0;
		irq_next = intr_req_reg && !intr_grant;
		ivec_next = intr_vector_reg;
		if (exec) begin
			pc_next = pc_reg + 10'h001; // RULE_04
			case (cls)
				CL_ALU: begin
					if (move && src_ent[6:5] == DST_BRLOAD)
						br_next = alu_y[7:0]; // RULE_03
					if (move && src_ent[6:5] == DST_BRSHIFT)
						br_next = {alu_y[7], branch_shift_reg[7:1]}; // RULE_03
					if (move || fn_ent[4])
						carry_next = alu_y[8]; // RULE_12
					if (move)
						equal_next = sp_a == mux_b; // RULE_13
				end
				CL_MISC: begin
					if (sub == SUB_MAR)
						mar_next = {instr[5:4], sp_a};
					if (sub == SUB_IO && !instr[11]) begin
						io_next = sp_a;
						ios_next = 1'b1;
					end
					if (sub == SUB_IO && instr[11]) begin
						irq_next = 1'b1; // RULE_21
						ivec_next = instr[10] ? vec_b_sw : vec_a_sw;
					end
				end
				CL_BRANCH: begin
					case (instr[13:12])
						2'b00: pc_next = instr[9:0];
						2'b01: if (carry_reg) pc_next = instr[9:0];
						2'b10: if (equal_reg) pc_next = instr[9:0];
						default: if (branch_shift_reg[0]) pc_next = instr[9:0];
					endcase
				end
				default: ;
			endcase
		end
	end

	always_comb begin
		dma_state_next = dma_state_reg;
		dwr_next = dma_write_reg;
		dby_next = dma_byte_reg;
		dkp_next = dma_keep_reg;
		dad_next = dma_addr_reg;
		dwd_next = dma_wdata_reg;
		din_next = dma_in_reg;
		case (dma_state_reg)
			DMA_IDLE: if (exec && cls == CL_MISC && sub == SUB_DMA) begin
				dma_state_next = DMA_BUSY; // RULE_20
				dwr_next = instr[11];
				dby_next = instr[10];
				dkp_next = instr[9];
				dad_next = {mp_ram[`MIP_MP_PTR_HI][1:0], mp_ram[`MIP_MP_PTR_MID], mp_ram[`MIP_MP_PTR_LO]};
				dwd_next = {mp_ram[`MIP_MP_DOUT_HI], mp_ram[`MIP_MP_DOUT_LO]};
			end
			DMA_BUSY: if (dma_done) begin
				dma_state_next = DMA_IDLE;
				if (!dma_write_reg)
					din_next = dma_rdata;
			end
			default: dma_state_next = DMA_IDLE;
		endcase
	end

	always_comb begin
		mi_next = maint_instr_reg;
		csh_next = cs_hold_reg;
		ma_next = maint_addr_reg;
		rd_next = bus_rdata_reg;
		ack_next = 1'b0;
		ctrl_hi_next = ctrl_hi_reg;
		csp_next = cs_we;
		if (mp_we && mp_waddr == 4'h1)
			ctrl_hi_next = mp_wdata;
		if (host_mp_wr && !bus_byte && reg_idx == 3'h0)
			ctrl_hi_next = bus_wdata[15:8];
		hwc_next = (host_wr_cnt_reg != 2'b00) ? host_wr_cnt_reg - 2'b01 : 2'b00;
		if (host_mp_wr)
			hwc_next = 2'(`MIP_HOST_WR_CYC);
		if (sel_hit && (bus_read || bus_write)) begin
			ack_next = 1'b1;
			if (bus_read) begin
				case (reg_idx)
					`MIP_REG_MAINT_INSTR: rd_next = maint_instr_reg;
					`MIP_REG_CS_DATA: rd_next = control_store[maint_addr_reg];
					`MIP_REG_MAINT_ADDR: rd_next = {6'h00, maint_addr_reg};
					3'h7: rd_next = 16'h0000;
					default: rd_next = {mp_ram[{1'b0, reg_idx[1:0], 1'b1}], mp_ram[{1'b0, reg_idx[1:0], 1'b0}]};
				endcase
			end else if (!bus_byte) begin
				case (reg_idx)
					`MIP_REG_MAINT_INSTR: mi_next = bus_wdata;
					`MIP_REG_CS_DATA: csh_next = bus_wdata;
					`MIP_REG_MAINT_ADDR: ma_next = bus_wdata[9:0];
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pc_reg <= 10'h000;
			data_mem_addr_reg <= 10'h000;
			branch_shift_reg <= `MIP_BYTE_RST;
			carry_reg <= 1'b0;
			equal_reg <= 1'b0;
			maint_instr_reg <= `MIP_WORD_RST;
			cs_hold_reg <= `MIP_WORD_RST;
			maint_addr_reg <= 10'h000;
			bus_rdata_reg <= `MIP_WORD_RST;
			bus_ack_reg <= 1'b0;
			host_wr_cnt_reg <= 2'b00;
			dma_state_reg <= DMA_IDLE;
			dma_write_reg <= 1'b0;
			dma_byte_reg <= 1'b0;
			dma_keep_reg <= 1'b0;
			dma_addr_reg <= 18'h0_0000;
			dma_wdata_reg <= `MIP_WORD_RST;
			dma_in_reg <= `MIP_WORD_RST;
			intr_req_reg <= 1'b0;
			intr_vector_reg <= 9'h000;
			intr_level_reg <= 3'(INTR_LEVEL);
			io_out_reg <= `MIP_BYTE_RST;
			io_strobe_reg <= 1'b0;
			running_reg <= 1'b0;
			ctrl_hi_reg <= `MIP_BYTE_RST;
			cs_pend_reg <= 1'b0;
		end else if (ce) begin
			pc_reg <= pc_next;
			data_mem_addr_reg <= mar_next;
			branch_shift_reg <= br_next;
			carry_reg <= carry_next;
			equal_reg <= equal_next;
			maint_instr_reg <= mi_next;
			cs_hold_reg <= csh_next;
			maint_addr_reg <= ma_next;
			bus_rdata_reg <= rd_next;
			bus_ack_reg <= ack_next;
			host_wr_cnt_reg <= hwc_next;
			dma_state_reg <= dma_state_next;
			dma_write_reg <= dwr_next;
			dma_byte_reg <= dby_next;
			dma_keep_reg <= dkp_next;
			dma_addr_reg <= dad_next;
			dma_wdata_reg <= dwd_next;
			dma_in_reg <= din_next;
			intr_req_reg <= irq_next;
			intr_vector_reg <= ivec_next;
			io_out_reg <= io_next;
			io_strobe_reg <= ios_next;
			running_reg <= run;
			ctrl_hi_reg <= ctrl_hi_next;
			cs_pend_reg <= csp_next;
		end
	end

	assign bus_rdata = bus_rdata_reg;
	assign bus_ack = bus_ack_reg;
	assign dma_req = dma_state_reg == DMA_BUSY;
	assign dma_write = dma_write_reg;
	assign dma_byte = dma_byte_reg;
	assign dma_keep_master = dma_keep_reg; // RULE_20
	assign dma_addr = dma_addr_reg;
	assign dma_wdata = dma_wdata_reg;
	assign intr_req = intr_req_reg;
	assign intr_vector = intr_vector_reg;
	assign intr_level = intr_level_reg;
	assign io_out_data = io_out_reg;
	assign io_out_strobe = io_strobe_reg;
	assign running = running_reg;
endmodule

//--- logic/mip_regs.svh
// Offsets, field positions, reset values and timing counts of the I/O processor core.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef MIP_REGS_SVH
`define MIP_REGS_SVH
`define MIP_CLK_NS 25
`define MIP_PHASE_NS 60
`define MIP_CYCLE_NS 300
`define MIP_PHASE_CYC (`MIP_PHASE_NS / `MIP_CLK_NS)
`define MIP_CYCLE_CYC (`MIP_CYCLE_NS / `MIP_CLK_NS)
`define MIP_HOST_WR_CYC 2
`define MIP_REG_MP_LAST 3'h3
`define MIP_REG_MAINT_INSTR 3'h4
`define MIP_REG_CS_DATA 3'h5
`define MIP_REG_MAINT_ADDR 3'h6
`define MIP_CTRL_RUN_BIT 15
`define MIP_CTRL_CSWR_BIT 13
`define MIP_CTRL_MAINT_BIT 10
`define MIP_MP_PTR_LO 4'h8
`define MIP_MP_PTR_MID 4'h9
`define MIP_MP_PTR_HI 4'hA
`define MIP_MP_DOUT_LO 4'hC
`define MIP_MP_DOUT_HI 4'hD
`define MIP_WORD_RST 16'h0000
`define MIP_BYTE_RST 8'h00
`endif

//--- logic/mip_pkg.sv
// Types shared by the I/O processor core and its phase generator.
// Assumes nothing beyond a SystemVerilog elaborator.
package mip_pkg;
	typedef enum logic [1:0] {CL_ALU = 2'b00, CL_MISC = 2'b01, CL_IMM = 2'b10, CL_BRANCH = 2'b11} mip_class_e;
	typedef enum logic [1:0] {SUB_MPWR = 2'b00, SUB_DMA = 2'b01, SUB_IO = 2'b10, SUB_MAR = 2'b11} mip_sub_e;
	typedef enum logic [1:0] {DST_SP = 2'b00, DST_BRLOAD = 2'b01, DST_BRSHIFT = 2'b10, DST_MEM = 2'b11} mip_dest_e;
	typedef enum logic [2:0] {SRC_BRANCH = 3'h0, SRC_MEM = 3'h1, SRC_MPA = 3'h2, SRC_MPB = 3'h3,
		SRC_DMA_LO = 3'h4, SRC_DMA_HI = 3'h5, SRC_IO = 3'h6, SRC_ZERO = 3'h7} mip_src_e;
	typedef enum logic [2:0] {PG_HALT = 3'b001, PG_RUN = 3'b010, PG_HOLD = 3'b100} mip_pg_state_e;
	typedef enum logic [1:0] {DMA_IDLE = 2'b01, DMA_BUSY = 2'b10} mip_dma_state_e;
endpackage

//--- logic/mip_phase_gen.sv
// Five-phase microcycle generator of the I/O processor core.
// Assumes run and stall are synchronous to core_clk.
`timescale 1ns/10ps
`include "mip_regs.svh"
module mip_phase_gen import mip_pkg::*; #(
	parameter int PHASE_CYC = `MIP_PHASE_CYC,
	parameter int CYCLE_CYC = `MIP_CYCLE_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	input wire logic stall,
	output logic [4:0] phase,
	output logic exec
);
	initial begin
		if (PHASE_CYC < 1 || CYCLE_CYC < 5 * PHASE_CYC || CYCLE_CYC > 255)
			$error("phase generator counts out of range");
	end
	localparam logic [7:0] LAST = 8'(CYCLE_CYC - 1);
	mip_pg_state_e state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [4:0] phase_reg, phase_next;

	// Holding at the last count freezes the cycle until the conflict clears
	assign exec = (state_reg != PG_HALT) && cnt_reg == LAST && !stall; // RULE_18 RULE_19
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			PG_HALT: if (run) begin
				state_next = PG_RUN;
				cnt_next = 8'h00;
			end
			PG_RUN, PG_HOLD: begin
				if (cnt_reg != LAST) begin
					cnt_next = cnt_reg + 8'h01;
				end else if (stall) begin
					state_next = PG_HOLD;
				end else begin
					cnt_next = 8'h00;
					state_next = run ? PG_RUN : PG_HALT;
				end
			end
			default: state_next = PG_HALT;
		endcase
	end
	// Non-overlapping pulses, one per phase slot, idle tail fills the cycle
	genvar k;
	generate
		for (k = 0; k < 5; k++) begin : g_ph
			assign phase_next[k] = (state_next != PG_HALT) && cnt_next >= 8'(k * PHASE_CYC)
				&& cnt_next < 8'((k + 1) * PHASE_CYC); // RULE_16
		end
	endgenerate
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= PG_HALT;
			cnt_reg <= 8'h00;
			phase_reg <= 5'h00;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			phase_reg <= phase_next;
		end
	end
	assign phase = phase_reg;
endmodule

//--- tb/mip_core_checker.sv
// Port-level assertions for the I/O processor core, bound into every instance.
// Assumes one core clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
module mip_core_checker import mip_pkg::*; #(
	parameter int INTR_LEVEL = 5
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [17:0] bus_addr,
	input wire logic [17:4] dev_addr_sw,
	input wire logic bus_read,
	input wire logic bus_write,
	input wire logic bus_ack,
	input wire logic dma_req,
	input wire logic dma_done,
	input wire logic [17:0] dma_addr,
	input wire logic intr_req,
	input wire logic intr_grant,
	input wire logic [2:0] intr_level,
	input wire logic io_out_strobe,
	input wire logic [4:0] clk_phase,
	input wire logic running
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic hit;
	assign hit = ce && (bus_read || bus_write) && bus_addr[17:4] == dev_addr_sw;
	chk_ack_taken: assert property (hit |=> bus_ack)
		else $error("bus ack missing after a decoded request");
	chk_ack_only: assert property (!hit |=> !bus_ack)
		else $error("bus ack without a decoded request");
	chk_phase_onehot: assert property ($onehot0(clk_phase))
		else $error("phase pulses overlap");
	chk_phase_order: assert property ($rose(clk_phase[0]) |-> clk_phase[0] [*2] ##1 clk_phase[1] [*2]
		##1 clk_phase[2] [*2] ##1 clk_phase[3] [*2] ##1 clk_phase[4] [*2])
		else $error("phase pulses out of order or of wrong width");
	chk_phase_idle: assert property ($fell(clk_phase[4]) |-> (clk_phase == 5'h00) [*2])
		else $error("microcycle shorter than twelve clocks");
	chk_stopped: assert property (!running && !$past(running) |-> clk_phase == 5'h00)
		else $error("phase pulse while stopped");
	chk_level_fixed: assert property (intr_level == 3'(INTR_LEVEL))
		else $error("interrupt level differs from its setting");
	chk_intr_held: assert property (intr_req && !intr_grant |=> intr_req)
		else $error("interrupt request dropped before grant");
	chk_dma_held: assert property (dma_req && !dma_done |=> dma_req && $stable(dma_addr))
		else $error("transfer request changed before done");
	chk_strobe_pulse: assert property (io_out_strobe |=> !io_out_strobe)
		else $error("output strobe longer than one clock");
endmodule
bind mip_core mip_core_checker #(.INTR_LEVEL(INTR_LEVEL)) u_mip_core_checker (
	.core_clk(core_clk), .rst(rst), .ce(ce), .bus_addr(bus_addr), .dev_addr_sw(dev_addr_sw),
	.bus_read(bus_read), .bus_write(bus_write), .bus_ack(bus_ack), .dma_req(dma_req), .dma_done(dma_done),
	.dma_addr(dma_addr), .intr_req(intr_req), .intr_grant(intr_grant), .intr_level(intr_level),
	.io_out_strobe(io_out_strobe), .clk_phase(clk_phase), .running(running)
);

//--- tb/mip_host_model.sv
// Host processor model: register-cycle master, transfer slave and interrupt acknowledger.
// Assumes the core answers a decoded request one clock after taking it.
`timescale 1ns/10ps
module mip_host_model import mip_pkg::*; (
	input wire logic core_clk,
	output logic [17:0] bus_addr,
	output logic bus_read,
	output logic bus_write,
	output logic bus_byte,
	output logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	input wire logic bus_ack,
	input wire logic dma_req,
	output logic dma_done,
	output logic [15:0] dma_rdata,
	input wire logic intr_req,
	input wire logic [8:0] intr_vector,
	output logic intr_grant
);
	int dma_lat = 2;
	int dma_seen = 0;
	int intr_seen = 0;
	logic [8:0] vec_got = 9'h000;
	initial begin
		bus_addr = 18'h0_0000;
		bus_read = 1'b0;
		bus_write = 1'b0;
		bus_byte = 1'b0;
		bus_wdata = 16'h0000;
		dma_done = 1'b0;
		dma_rdata = 16'h0000;
		intr_grant = 1'b0;
	end
	// Strobe is a one-clock pulse; address and data stay until the answer is sampled
	task automatic xfer(input logic [17:0] a, input logic wr, input logic bt, input logic [15:0] wd,
		output logic [15:0] rd, output logic ack);
		@(posedge core_clk);
		bus_addr <= a;
		bus_write <= wr;
		bus_read <= !wr;
		bus_byte <= bt;
		bus_wdata <= wd;
		@(posedge core_clk);
		bus_write <= 1'b0;
		bus_read <= 1'b0;
		@(negedge core_clk);
		ack = bus_ack;
		rd = bus_rdata;
		@(posedge core_clk);
		// Released data lines show garbage, so a stale value cannot pass
		bus_wdata <= ~wd;
	endtask
	always begin
		@(posedge core_clk);
		dma_rdata <= ~dma_rdata;
		if (dma_req === 1'b1) begin
			dma_seen++;
			repeat (dma_lat) @(posedge core_clk);
			dma_done <= 1'b1;
			@(posedge core_clk);
			dma_done <= 1'b0;
			@(posedge core_clk);
		end
	end
	always @(posedge core_clk) begin
		if (intr_req === 1'b1 && intr_grant !== 1'b1) begin
			intr_seen++;
			vec_got <= intr_vector;
			intr_grant <= 1'b1;
		end else begin
			intr_grant <= 1'b0;
		end
	end
endmodule

//--- tb/mip_core_bench.sv
// Self-checking bench for the I/O processor core with the host model on its bus side.
// Assumes the package, the core, the checker and the host model are compiled first.
`timescale 1ns/10ps
module mip_core_bench import mip_pkg::*;;
	localparam logic [17:4] BASE = 14'h3F04;
	// Arbitrary switch vectors
	localparam logic [8:0] VEC_A = 9'h0C0;
	localparam logic [8:0] VEC_B = 9'h0C4;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b0;
	logic [7:0] io_in = 8'h3C;
	logic [17:0] bus_addr, dma_addr;
	logic [15:0] bus_wdata, bus_rdata, dma_wdata, dma_rdata;
	logic bus_read, bus_write, bus_byte, bus_ack, dma_req, dma_write, dma_byte, dma_keep_master, dma_done;
	logic intr_req, intr_grant, io_out_strobe, running;
	logic [8:0] intr_vector;
	logic [2:0] intr_level;
	logic [7:0] io_out_data;
	logic [4:0] clk_phase;
	logic [7:0] outs [$];
	int err_total = 0;
	int checked = 0;
	// Loads, output of sp0 with field 1, branch load, shift, carry branch, interrupt,
	// memory round trip skipping an output on equal, pointer writes, transfer, halt loop
	logic [15:0] prog [27] = '{16'h85A0, 16'h8A51, 16'h6001, 16'h1E81, 16'h0070, 16'h6000, 16'h2E81,
		16'h0070, 16'h6000, 16'h0001, 16'hD00C, 16'h6000, 16'h83C0, 16'h6000, 16'h6C00, 16'h7010,
		16'h3E81, 16'h1271, 16'hE014, 16'h6000, 16'h4081, 16'h4090, 16'h40A1, 16'h40C0, 16'h40D1,
		16'h5A00, 16'hC01A};
	mip_core u_mip_core (
		.core_clk(core_clk), .rst(rst), .ce(ce), .bus_addr(bus_addr), .dev_addr_sw(BASE),
		.bus_read(bus_read), .bus_write(bus_write), .bus_byte(bus_byte), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack), .dma_req(dma_req), .dma_write(dma_write), .dma_byte(dma_byte),
		.dma_keep_master(dma_keep_master), .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_done(dma_done),
		.dma_rdata(dma_rdata), .intr_req(intr_req), .intr_vector(intr_vector), .intr_level(intr_level),
		.intr_grant(intr_grant), .vec_a_sw(VEC_A), .vec_b_sw(VEC_B), .io_in(io_in), .io_out_data(io_out_data),
		.io_out_strobe(io_out_strobe), .clk_phase(clk_phase), .running(running)
	);
	mip_host_model u_mip_host_model (
		.core_clk(core_clk), .bus_addr(bus_addr), .bus_read(bus_read), .bus_write(bus_write),
		.bus_byte(bus_byte), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.dma_req(dma_req), .dma_done(dma_done), .dma_rdata(dma_rdata), .intr_req(intr_req),
		.intr_vector(intr_vector), .intr_grant(intr_grant)
	);
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) if (io_out_strobe === 1'b1) outs.push_back(io_out_data);
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] idx, input logic [15:0] d);
		logic [15:0] r;
		logic a;
		u_mip_host_model.xfer({BASE, idx, 1'b0}, 1'b1, 1'b0, d, r, a);
		cmp({15'h0000, a}, 16'h0001);
	endtask
	task automatic rd(input logic [2:0] idx, input logic [15:0] exp);
		logic [15:0] r;
		logic a;
		u_mip_host_model.xfer({BASE, idx, 1'b0}, 1'b0, 1'b0, 16'h0000, r, a);
		cmp({15'h0000, a}, 16'h0001);
		cmp(r, exp);
	endtask
	task automatic t_host();
		logic [15:0] r;
		logic a;
		wr(3'h1, 16'h1234);
		rd(3'h1, 16'h1234);
		u_mip_host_model.xfer({BASE, 3'h1, 1'b1}, 1'b1, 1'b1, 16'hABAB, r, a);
		rd(3'h1, 16'hAB34);
		u_mip_host_model.xfer({~BASE, 3'h1, 1'b0}, 1'b1, 1'b0, 16'h5555, r, a);
		cmp({15'h0000, a}, 16'h0000);
		rd(3'h1, 16'hAB34);
		wr(3'h6, 16'h0005);
		u_mip_host_model.xfer({BASE, 3'h6, 1'b0}, 1'b1, 1'b1, 16'h0303, r, a);
		rd(3'h6, 16'h0005);
		rd(3'h7, 16'h0000);
		$display("host register test done");
	endtask
	task automatic t_load();
		wr(3'h0, 16'h2400);
		wr(3'h4, 16'h0000);
		for (int i = 0; i < 27; i++) begin
			wr(3'h6, 16'(i));
			wr(3'h5, prog[i]);
		end
		for (int i = 0; i < 27; i++) begin
			wr(3'h6, 16'(i));
			rd(3'h5, prog[i]);
		end
		$display("control store test done");
	endtask
	task automatic t_run();
		int n;
		wr(3'h0, 16'h8000);
		for (n = 0; n < 600 && dma_req !== 1'b1; n++) @(negedge core_clk);
		cmp({15'h0000, running}, 16'h0001);
		cmp({12'h000, dma_addr[17:16], dma_write, dma_byte}, 16'h000E);
		cmp(dma_addr[15:0], 16'h3C77);
		cmp(dma_wdata, 16'h773C);
		repeat (8) @(negedge core_clk);
		cmp({14'h0000, dma_req, dma_keep_master}, 16'h0001);
		cmp(16'(u_mip_host_model.dma_seen), 16'h0001);
		cmp(16'(outs.size()), 16'h0004);
		cmp({8'h00, outs[0]}, 16'h005A);
		cmp({8'h00, outs[1]}, 16'h00A5);
		cmp({8'h00, outs[2]}, 16'h00D2);
		cmp({8'h00, outs[3]}, 16'h003C);
		cmp(16'(u_mip_host_model.intr_seen), 16'h0001);
		cmp({7'h00, u_mip_host_model.vec_got}, {7'h00, VEC_B});
		cmp({13'h0000, intr_level}, 16'h0005);
		$display("microprogram run test done");
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		ce <= 1'b1;
		@(negedge core_clk);
		cmp({10'h000, running, clk_phase}, 16'h0000);
		t_host();
		t_load();
		t_run();
		stop_test();
	end
	// Whole run needs well under a thousand clocks
	initial begin
		repeat (5000) @(posedge core_clk);
		err_total++;
		$display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
		stop_test();
	end
endmodule
